// file: shared/pdm_pkg.sv
// constants, types and carriers for the power-down mode control block
// assumes a 32-bit AXI4-Lite master and same-clock cpu/intc/dma strobes
// Contract
// - sleep instruction with deep-halt select 0 enters sleep; bit resets to 0
// - sleep instruction with deep-halt select 1 enters standby, halting all
// - cpu stops right after sleep instruction, registers kept
// - in sleep clock and peripherals run, ram and ports held
// - in either power-down mode cpu execution stops, registers and ram kept
// - control register is 8-bit read/write at 0x5ffffbc, resets to 0x1f
// - deep-halt select bit 7 cannot be set while watchdog enabled
// - port-float select bit 6 cannot be set while watchdog enabled
// - in standby ports hold when float select 0, float when 1
// - bit 5 reads 0, bits 4 to 0 ignore writes and read 1
// - accepted interrupt ends sleep, then interrupt exception processing
// - interrupt at or below cpu mask level does not end sleep
// - interrupt disabled at its source does not end sleep
// - dma address error ends sleep with its exception processing
// - reset pin low with nmi high leaves sleep into power-on reset
// - reset pin low with nmi low leaves sleep into manual reset
// - nmi rising edge, when selected, ends sleep as nmi interrupt
// - nmi falling edge, when selected, ends sleep as nmi interrupt
// - standby ends only on nmi, power-on or manual reset
package pdm_pkg;

   localparam int          ADDR_W         = 28;
   localparam logic [27:0] PDC_ADDR       = 28'h5ffffbc;
   localparam logic [7:0]  PDC_RESET      = 8'h1f;
   localparam int          DEEP_HALT_BIT  = 7;
   localparam int          PORT_FLOAT_BIT = 6;
   localparam int          ZERO_BIT       = 5;
   localparam logic [4:0]  ONES_FIELD     = 5'h1f;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_DECERR    = 2'h3;

   typedef enum logic [1:0]
   {
      PDM_RUN     = 2'b00,
      PDM_SLEEP   = 2'b01,
      PDM_STANDBY = 2'b10
   } pdm_state_t;

   typedef struct packed
   {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } pdm_axi_req_t;

   typedef struct packed
   {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } pdm_axi_rsp_t;

   typedef struct packed
   {
      logic       request;
      logic [3:0] level;
      logic       srcEnabled;
   } pdm_irq_t;

   typedef struct packed
   {
      logic wakeIrq;
      logic wakeDmaErr;
      logic wakeNmi;
      logic powerOnReset;
      logic manualReset;
   } pdm_wake_t;

endpackage

// file: hdl/pdm_power_down_ctrl.sv
// power-down mode control: sleep/standby state, control register, wake logic
// assumes sleep, irq, mask, dma and watchdog inputs are on ref_clk;
// reset pin and nmi pin are asynchronous and synchronised here
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
module pdm_power_down_ctrl
(
   input  wire logic                  ref_clk,
   input  wire logic                  rstn,
   input  wire pdm_pkg::pdm_axi_req_t axiReq,
   output      pdm_pkg::pdm_axi_rsp_t axiRsp,
   input  wire logic                  sleepExec,
   input  wire logic                  watchdogRunEnable,
   input  wire pdm_pkg::pdm_irq_t     irqIn,
   input  wire logic [3:0]            cpuMaskLevel,
   input  wire logic                  dmaAddrError,
   input  wire logic                  nmiEdgeSelect,
   input  wire logic                  resetPinN,
   input  wire logic                  nmiPin,
   output      logic [1:0]            powerState,
   output      logic                  cpuHalt,
   output      logic                  clockHalt,
   output      logic                  periphHalt,
   output      logic                  portFloat,
   output      pdm_pkg::pdm_wake_t    wake
);
   import pdm_pkg::*;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   pdm_state_t        state_ff;
   pdm_state_t        nxt_state;
   logic              deepHalt_ff;
   logic              portFloatSel_ff;
   logic              rstSync1_ff;
   logic              rstSync2_ff;
   logic              nmiSync1_ff;
   logic              nmiSync2_ff;
   logic              nmiPrev_ff;
   logic              awHave_ff;
   logic              wHave_ff;
   logic [ADDR_W-1:0] awAddr_ff;
   logic [7:0]        wByte_ff;
   logic              wLane_ff;
   logic              bvalid_ff;
   logic [1:0]        bresp_ff;
   logic              rvalid_ff;
   logic [31:0]       rdata_ff;
   logic [1:0]        rresp_ff;
   logic              cpuHalt_ff;
   logic              clockHalt_ff;
   logic              periphHalt_ff;
   logic              portFloat_ff;
   pdm_wake_t         wake_ff;
   logic              resetLow;
   logic              nmiEdge;
   logic              irqAccept;
   logic              regWrite;
   logic [7:0]        regByte;

   function automatic logic lockedBit(input logic oldBit,
                                      input logic newBit,
                                      input logic wdtOn);
      lockedBit = (wdtOn && newBit && !oldBit) ? oldBit : newBit;
   endfunction

   // pin synchronisers
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rstSync1_ff <= 1'b1;
         rstSync2_ff <= 1'b1;
         nmiSync1_ff <= 1'b0;
         nmiSync2_ff <= 1'b0;
         nmiPrev_ff  <= 1'b0;
      end
      else
      begin
         rstSync1_ff <= resetPinN;
         rstSync2_ff <= rstSync1_ff;
         nmiSync1_ff <= nmiPin;
         nmiSync2_ff <= nmiSync1_ff;
         nmiPrev_ff  <= nmiSync2_ff;
      end
   end

   assign resetLow = !rstSync2_ff;

   assign nmiEdge = nmiEdgeSelect ? (nmiSync2_ff && !nmiPrev_ff)
                                  : (!nmiSync2_ff && nmiPrev_ff);

   assign irqAccept = irqIn.request && irqIn.srcEnabled &&
                      (irqIn.level > cpuMaskLevel);

   assign regByte = {deepHalt_ff, portFloatSel_ff, 1'b0, ONES_FIELD};

   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         PDM_RUN:
         begin
            if (sleepExec && !resetLow)
               nxt_state = deepHalt_ff ? PDM_STANDBY : PDM_SLEEP;
         end
         PDM_SLEEP:
         begin
            if (resetLow || nmiEdge || dmaAddrError || irqAccept)
               nxt_state = PDM_RUN;
         end
         PDM_STANDBY:
         begin
            // only nmi or reset ends standby
            if (resetLow || nmiEdge)
               nxt_state = PDM_RUN;
         end
         default:
            nxt_state = PDM_RUN;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         state_ff <= PDM_RUN;
      else
         state_ff <= nxt_state;
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cpuHalt_ff    <= 1'b0;
         clockHalt_ff  <= 1'b0;
         periphHalt_ff <= 1'b0;
         portFloat_ff  <= 1'b0;
      end
      else
      begin
         cpuHalt_ff    <= (nxt_state != PDM_RUN);
         clockHalt_ff  <= (nxt_state == PDM_STANDBY);
         periphHalt_ff <= (nxt_state == PDM_STANDBY);
         portFloat_ff  <= (nxt_state == PDM_STANDBY) && portFloatSel_ff;
      end
   end

   // wake reasons and reset requests
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         wake_ff <= '0;
      else
      begin
         wake_ff.powerOnReset <= resetLow && nmiSync2_ff;
         wake_ff.manualReset  <= resetLow && !nmiSync2_ff;
         wake_ff.wakeNmi      <= !resetLow && nmiEdge &&
                                 (state_ff != PDM_RUN);
         wake_ff.wakeDmaErr   <= !resetLow && !nmiEdge && dmaAddrError &&
                                 (state_ff == PDM_SLEEP);
         wake_ff.wakeIrq      <= !resetLow && !nmiEdge && !dmaAddrError &&
                                 irqAccept && (state_ff == PDM_SLEEP);
      end
   end

   // axi write address and data capture
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         awHave_ff <= 1'b0;
         wHave_ff  <= 1'b0;
         awAddr_ff <= '0;
         wByte_ff  <= 8'h00;
         wLane_ff  <= 1'b0;
      end
      else
      begin
         if (axiReq.awvalid && axiRsp.awready)
         begin
            awHave_ff <= 1'b1;
            awAddr_ff <= axiReq.awaddr;
         end
         else if (regWrite)
            awHave_ff <= 1'b0;
         if (axiReq.wvalid && axiRsp.wready)
         begin
            wHave_ff <= 1'b1;
            wByte_ff <= axiReq.wdata[7:0];
            wLane_ff <= axiReq.wstrb[0];
         end
         else if (regWrite)
            wHave_ff <= 1'b0;
      end
   end

   assign regWrite = awHave_ff && wHave_ff && !bvalid_ff;

   // write response
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end
      else if (regWrite)
      begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= (awAddr_ff[ADDR_W-1:2] == PDC_ADDR[ADDR_W-1:2])
                      ? RESP_OKAY : RESP_DECERR;
      end
      else if (axiReq.bready)
         bvalid_ff <= 1'b0;
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         deepHalt_ff     <= PDC_RESET[DEEP_HALT_BIT];
         portFloatSel_ff <= PDC_RESET[PORT_FLOAT_BIT];
      end
      else if (regWrite && wLane_ff &&
               awAddr_ff[ADDR_W-1:2] == PDC_ADDR[ADDR_W-1:2])
      begin
         deepHalt_ff     <= lockedBit(deepHalt_ff,
                                      wByte_ff[DEEP_HALT_BIT],
                                      watchdogRunEnable);
         portFloatSel_ff <= lockedBit(portFloatSel_ff,
                                      wByte_ff[PORT_FLOAT_BIT],
                                      watchdogRunEnable);
      end
   end

   // axi read channel
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
         rresp_ff  <= RESP_OKAY;
      end
      else if (axiReq.arvalid && !rvalid_ff)
      begin
         rvalid_ff <= 1'b1;
         if (axiReq.araddr[ADDR_W-1:2] == PDC_ADDR[ADDR_W-1:2])
         begin
            rdata_ff <= {24'h00_0000, regByte};
            rresp_ff <= RESP_OKAY;
         end
         else
         begin
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_DECERR;
         end
      end
      else if (axiReq.rready)
         rvalid_ff <= 1'b0;
   end

   always_comb
   begin
      axiRsp.awready = !awHave_ff && !bvalid_ff;
      axiRsp.wready  = !wHave_ff && !bvalid_ff;
      axiRsp.bvalid  = bvalid_ff;
      axiRsp.bresp   = bresp_ff;
      axiRsp.arready = !rvalid_ff;
      axiRsp.rvalid  = rvalid_ff;
      axiRsp.rdata   = rdata_ff;
      axiRsp.rresp   = rresp_ff;
   end

   assign powerState = state_ff;
   assign cpuHalt    = cpuHalt_ff;
   assign clockHalt  = clockHalt_ff;
   assign periphHalt = periphHalt_ff;
   assign portFloat  = portFloat_ff;
   assign wake       = wake_ff;

   sequence seq_sleep_cmd;
      state_ff == PDM_RUN && sleepExec && !resetLow;
   endsequence

   sequence seq_sleep_quiet;
      state_ff == PDM_SLEEP && !resetLow && !nmiEdge && !dmaAddrError;
   endsequence

   chk_sleep_entry: assert property (
      seq_sleep_cmd and (!deepHalt_ff) |=> state_ff == PDM_SLEEP
                                          && cpuHalt && !clockHalt)
      else $error("sleep not entered");

   chk_standby_entry: assert property (
      seq_sleep_cmd and (deepHalt_ff) |=> state_ff == PDM_STANDBY
                                         && clockHalt && periphHalt)
      else $error("standby not entered");

   chk_cpu_halt: assert property (
      seq_sleep_cmd |=> cpuHalt)
      else $error("cpu not halted after sleep");

   chk_sleep_clock_runs: assert property (
      state_ff == PDM_SLEEP |-> !clockHalt && !periphHalt && !portFloat)
      else $error("clock halted in sleep");

   chk_powerdown_halt: assert property (
      state_ff != PDM_RUN |-> cpuHalt)
      else $error("cpu running in power-down");

   chk_reg_layout: assert property (
      rvalid_ff && rresp_ff == RESP_OKAY
      |-> rdata_ff[ZERO_BIT] == 1'b0 && rdata_ff[4:0] == ONES_FIELD
          && rdata_ff[31:8] == 24'h00_0000)
      else $error("reserved bits wrong");

   chk_deep_lock: assert property (
      regWrite && watchdogRunEnable && !deepHalt_ff |=> !deepHalt_ff)
      else $error("deep-halt set under watchdog");

   chk_float_lock: assert property (
      regWrite && watchdogRunEnable && !portFloatSel_ff
      |=> !portFloatSel_ff)
      else $error("port-float set under watchdog");

   chk_port_float: assert property (
      state_ff == PDM_STANDBY && $stable(state_ff)
      |-> portFloat == portFloatSel_ff)
      else $error("port float mismatch in standby");

   chk_irq_wake: assert property (
      seq_sleep_quiet and irqAccept |=> state_ff == PDM_RUN
                                       && wake.wakeIrq)
      else $error("accepted irq did not wake");

   chk_masked_irq: assert property (
      seq_sleep_quiet and (irqIn.level <= cpuMaskLevel)
      |=> state_ff == PDM_SLEEP)
      else $error("masked irq woke sleep");

   chk_dma_wake: assert property (
      state_ff == PDM_SLEEP && dmaAddrError && !resetLow && !nmiEdge
      |=> state_ff == PDM_RUN && wake.wakeDmaErr)
      else $error("dma error did not wake");

   chk_por_kind: assert property (
      resetLow && nmiSync2_ff |=> wake.powerOnReset && !wake.manualReset)
      else $error("power-on reset not flagged");

   chk_manual_kind: assert property (
      resetLow && !nmiSync2_ff |=> wake.manualReset && !wake.powerOnReset)
      else $error("manual reset not flagged");

   chk_nmi_wake: assert property (
      state_ff != PDM_RUN && nmiEdge && !resetLow
      |=> state_ff == PDM_RUN && wake.wakeNmi ##1 !wake.wakeNmi[*2])
      else $error("nmi edge did not wake");

   chk_standby_hold: assert property (
      state_ff == PDM_STANDBY && !nmiEdge && !resetLow
      |=> state_ff == PDM_STANDBY)
      else $error("standby left without nmi or reset");

endmodule

// file: test/pdm_cpu_model.sv
// stand-in for cpu core, interrupt controller and dma of the power-down block
// assumes the bench calls its tasks from the ref_clk domain
`timescale 1ns/1ps
module pdm_cpu_model
(
   input  wire logic              ref_clk,
   output      logic              sleepExec,
   output      logic              watchdogRunEnable,
   output      pdm_pkg::pdm_irq_t irqIn,
   output      logic [3:0]        cpuMaskLevel,
   output      logic              dmaAddrError,
   output      logic              nmiEdgeSelect,
   output      logic              resetPinN,
   output      logic              nmiPin
);
   import pdm_pkg::*;
   initial
   begin
      sleepExec = 1'b0;
      watchdogRunEnable = 1'b0;
      irqIn = '0;
      cpuMaskLevel = 4'h0;
      dmaAddrError = 1'b0;
      nmiEdgeSelect = 1'b1;
      resetPinN = 1'b1;
      nmiPin = 1'b0;
   end
   // one-cycle sleep instruction strobe
   task sleep_op;
      @(posedge ref_clk);
      sleepExec <= 1'b1;
      @(posedge ref_clk);
      sleepExec <= 1'b0;
   endtask
   // watchdog enable, nmi edge choice and the two pins
   task set(input logic w, input logic s, input logic n, input logic r);
      @(posedge ref_clk);
      watchdogRunEnable <= w;
      nmiEdgeSelect <= s;
      nmiPin <= n;
      resetPinN <= r;
   endtask
   task irq(input logic q, input logic [3:0] l, input logic e,
            input logic [3:0] m);
      @(posedge ref_clk);
      irqIn <= '{request: q, level: l, srcEnabled: e};
      cpuMaskLevel <= m;
   endtask
   task dma_err;
      @(posedge ref_clk);
      dmaAddrError <= 1'b1;
      @(posedge ref_clk);
      dmaAddrError <= 1'b0;
   endtask
endmodule

// file: test/test_pdm_power_down_ctrl.sv
// self-checking bench for the power-down mode control block
// assumes the package and the cpu model are compiled first
`timescale 1ns/1ps
module test_pdm_power_down_ctrl;
   import pdm_pkg::*;
   logic         ref_clk;
   logic         rstn;
   pdm_axi_req_t axiReq;
   pdm_axi_rsp_t axiRsp;
   logic         sleepExec;
   logic         watchdogRunEnable;
   pdm_irq_t     irqIn;
   logic [3:0]   cpuMaskLevel;
   logic         dmaAddrError;
   logic         nmiEdgeSelect;
   logic         resetPinN;
   logic         nmiPin;
   logic [1:0]   powerState;
   logic         cpuHalt;
   logic         clockHalt;
   logic         periphHalt;
   logic         portFloat;
   pdm_wake_t    wake;
   pdm_wake_t    wakeSeen;
   logic         clrSeen;
   logic [31:0]  rd;
   logic [1:0]   rs;
   int           bad_count;
   int           comparisons;

   pdm_cpu_model part
   (
      .ref_clk(ref_clk), .sleepExec(sleepExec),
      .watchdogRunEnable(watchdogRunEnable), .irqIn(irqIn),
      .cpuMaskLevel(cpuMaskLevel), .dmaAddrError(dmaAddrError),
      .nmiEdgeSelect(nmiEdgeSelect), .resetPinN(resetPinN), .nmiPin(nmiPin)
   );
   pdm_power_down_ctrl dut
   (
      .ref_clk(ref_clk), .rstn(rstn), .axiReq(axiReq), .axiRsp(axiRsp),
      .sleepExec(sleepExec), .watchdogRunEnable(watchdogRunEnable),
      .irqIn(irqIn), .cpuMaskLevel(cpuMaskLevel),
      .dmaAddrError(dmaAddrError), .nmiEdgeSelect(nmiEdgeSelect),
      .resetPinN(resetPinN), .nmiPin(nmiPin), .powerState(powerState),
      .cpuHalt(cpuHalt), .clockHalt(clockHalt), .periphHalt(periphHalt),
      .portFloat(portFloat), .wake(wake)
   );

   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // sticky record of every wake output
   always @(posedge ref_clk)
      wakeSeen <= clrSeen ? '0 : (wakeSeen | wake);

   task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task limit(input int n);
      if (n >= 20)
      begin
         cmp("bus answer", 32'h1, 32'h0);
         stop_test;
      end
   endtask
   task axi_wr(input logic [27:0] a, input logic [7:0] d,
               input logic [3:0] s);
      int n;
      n = 0;
      @(posedge ref_clk);
      axiReq.awaddr <= a;
      axiReq.awvalid <= 1'b1;
      axiReq.wdata <= {24'h0, d};
      axiReq.wstrb <= s;
      axiReq.wvalid <= 1'b1;
      axiReq.bready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (axiRsp.awready)
            axiReq.awvalid <= 1'b0;
         if (axiRsp.wready)
            axiReq.wvalid <= 1'b0;
         n++;
      end
      while (!axiRsp.bvalid && n < 20);
      limit(n);
      rs = axiRsp.bresp;
      axiReq.bready <= 1'b0;
   endtask
   task axi_rd(input logic [27:0] a);
      int n;
      n = 0;
      @(posedge ref_clk);
      axiReq.araddr <= a;
      axiReq.arvalid <= 1'b1;
      axiReq.rready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (axiRsp.arready)
            axiReq.arvalid <= 1'b0;
         n++;
      end
      while (!axiRsp.rvalid && n < 20);
      limit(n);
      rd = axiRsp.rdata;
      rs = axiRsp.rresp;
      axiReq.rready <= 1'b0;
   endtask
   task wreg(input logic [7:0] d);
      axi_wr(PDC_ADDR, d, 4'hf);
      cmp("write resp", 32'(RESP_OKAY), 32'(rs));
   endtask
   task rreg(input logic [7:0] e);
      axi_rd(PDC_ADDR);
      cmp("reg read", {24'h0, e}, rd);
   endtask
   task wait_state(input logic [1:0] e);
      int n;
      n = 0;
      while (powerState !== e && n < 10)
      begin
         @(posedge ref_clk);
         n++;
      end
      cmp("power state", 32'(e), 32'(powerState));
      if (powerState !== e)
         stop_test;
   endtask
   task enter(input logic [1:0] e);
      @(posedge ref_clk);
      clrSeen <= 1'b1;
      @(posedge ref_clk);
      clrSeen <= 1'b0;
      part.sleep_op();
      wait_state(e);
   endtask
   task seen(input logic [4:0] e);
      @(posedge ref_clk);
      cmp("wake record", 32'(e), 32'(wakeSeen));
   endtask
   task hold_state(input logic [1:0] e);
      repeat (8) @(posedge ref_clk);
      cmp("state kept", 32'(e), 32'(powerState));
   endtask

   initial
   begin
      bad_count = 0;
      comparisons = 0;
      axiReq = '0;
      clrSeen = 1'b0;
      wakeSeen = '0;
      rstn = 1'b0;
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      rreg(8'h1f);
      cmp("reset state", 32'h0, 32'(powerState));
      part.set(1'b1, 1'b1, 1'b0, 1'b1);
      wreg(8'hff);
      rreg(8'h1f);
      part.set(1'b0, 1'b1, 1'b0, 1'b1);
      wreg(8'he0);
      rreg(8'hdf);
      part.set(1'b1, 1'b1, 1'b0, 1'b1);
      wreg(8'h40);
      rreg(8'h5f);
      wreg(8'hc0);
      rreg(8'h5f);
      axi_rd(PDC_ADDR + 28'h4);
      cmp("unmapped data", 32'h0, rd);
      cmp("unmapped resp", 32'(RESP_DECERR), 32'(rs));
      axi_wr(PDC_ADDR, 8'h00, 4'h0);
      cmp("masked wresp", 32'(RESP_OKAY), 32'(rs));
      rreg(8'h5f);
      axi_wr(PDC_ADDR + 28'h4, 8'h00, 4'hf);
      cmp("unmapped wresp", 32'(RESP_DECERR), 32'(rs));
      rreg(8'h5f);
      $display("test register done");
      part.set(1'b0, 1'b1, 1'b0, 1'b1);
      wreg(8'h1f);
      enter(2'b01);
      cmp("cpu halt", 32'h1, 32'(cpuHalt));
      cmp("sleep halts", 32'h0, {clockHalt, periphHalt, portFloat});
      part.irq(1'b1, 4'h3, 1'b1, 4'h3);
      hold_state(2'b01);
      part.irq(1'b1, 4'h4, 1'b0, 4'h3);
      hold_state(2'b01);
      part.irq(1'b1, 4'h4, 1'b1, 4'h3);
      wait_state(2'b00);
      seen(5'h10);
      part.irq(1'b0, 4'h4, 1'b1, 4'h3);
      enter(2'b01);
      part.dma_err();
      wait_state(2'b00);
      seen(5'h08);
      enter(2'b01);
      part.set(1'b0, 1'b1, 1'b1, 1'b1);
      wait_state(2'b00);
      seen(5'h04);
      part.set(1'b0, 1'b0, 1'b1, 1'b1);
      enter(2'b01);
      part.set(1'b0, 1'b0, 1'b0, 1'b1);
      wait_state(2'b00);
      seen(5'h04);
      $display("test sleep done");
      part.set(1'b0, 1'b1, 1'b0, 1'b1);
      wreg(8'h80);
      enter(2'b10);
      cmp("standby halts", 32'he, {cpuHalt, clockHalt, periphHalt,
          portFloat});
      part.irq(1'b1, 4'h9, 1'b1, 4'h0);
      part.dma_err();
      hold_state(2'b10);
      part.irq(1'b0, 4'h9, 1'b1, 4'h0);
      part.set(1'b0, 1'b1, 1'b1, 1'b1);
      wait_state(2'b00);
      seen(5'h04);
      wreg(8'hc0);
      enter(2'b10);
      cmp("port float", 32'h1, 32'(portFloat));
      part.set(1'b0, 1'b1, 1'b1, 1'b0);
      wait_state(2'b00);
      cmp("reset kind", 32'h2, {wake.powerOnReset, wake.manualReset});
      part.set(1'b0, 1'b1, 1'b0, 1'b1);
      enter(2'b10);
      part.set(1'b0, 1'b1, 1'b0, 1'b0);
      wait_state(2'b00);
      cmp("reset kind", 32'h1, {wake.powerOnReset, wake.manualReset});
      part.set(1'b0, 1'b1, 1'b0, 1'b1);
      $display("test standby done");
      stop_test;
   end
endmodule
